//--- rtl/crcs_top.sv
// Contract
// - answer only slave address 0x18
// - slave only, never drives SCL
// - eight-bit registers read back stored value
// - register address advances after each byte
// - works up to 400 kHz SCL
// - reset pin low restores all defaults
// - page 0 reg 1 bit 0 resets all
// - all blocks powered down after reset
// - memory init completes within 1 ms
// - PLL clocks withheld 10 ms after power-up
// - page 1 reg 31 bit 7 clears headphone trip
// - page 1 reg 32 bit 7 clears speaker trip
// - overcurrent latches stage off, reset only it
// - each block has its own power bit
// - power-down keeps register contents
`timescale 1ns/1ps
module crcs_top
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe_n,
	input wire logic hp_overcurrent,
	input wire logic spk_overcurrent,
	output logic init_busy,
	output logic pll_clk_enable,
	output logic adc_power_up,
	output logic dac_power_up,
	output logic headphone_output_enable,
	output logic speaker_out_enable
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic scl_s;
	logic sda_s;
	logic hp_oc_s;
	logic spk_oc_s;
	logic core_rstn;
	logic soft_rst_q;
	crcs_sync u_scl (.clock(clock), .rstn(core_rstn), .din(scl_in), .dout(scl_s));
	crcs_sync u_sda (.clock(clock), .rstn(core_rstn), .din(sda_in), .dout(sda_s));
	crcs_sync u_hoc (.clock(clock), .rstn(core_rstn), .din(~hp_overcurrent), .dout(hp_oc_s));
	crcs_sync u_soc (.clock(clock), .rstn(core_rstn), .din(~spk_overcurrent), .dout(spk_oc_s));
	// soft reset pulses the same async reset as the pin; 10 MHz sampling is
	// ample for 400 kHz SCL
	assign core_rstn = rstn & ~soft_rst_q;
	// ----------------------------------------
	// bus edge detection
	// ----------------------------------------
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;
	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] regs_q [0:crcs_pkg::REG_DEPTH-1];
	logic [7:0] regs1_q [0:crcs_pkg::REG_DEPTH-1];
	logic [7:0] page_q;
	logic wr_en;
	logic [7:0] wr_data;
	logic [7:0] ptr_q;
	logic [7:0] ptr_d;
	logic hp_trip_q;
	logic hp_trip_d;
	logic spk_trip_q;
	logic spk_trip_d;
	logic pll_done;
	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		logic [7:0] v;
		v = 8'h00;
		if (addr == crcs_pkg::PAGE_SEL_REG)
			v = page_q;
		else if (page_q == 8'h00 && addr == crcs_pkg::STATUS_REG)
			v = {4'h0, spk_trip_q, hp_trip_q, pll_done, init_busy};
		else if (addr < 8'(crcs_pkg::REG_DEPTH))
			v = (page_q == 8'h00) ? regs_q[addr[5:0]] : regs1_q[addr[5:0]];
		return v;
	endfunction
	// ----------------------------------------
	// slave state machine
	// ----------------------------------------
	typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} crcs_state_e;
	crcs_state_e st_q;
	crcs_state_e st_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [3:0] bit_q;
	logic [3:0] bit_d;
	logic rw_q;
	logic rw_d;
	logic first_q;
	logic first_d;
	logic drive_q;
	logic drive_d;
	always_comb
	begin
		st_d = st_q;
		sh_d = sh_q;
		bit_d = bit_q;
		rw_d = rw_q;
		first_d = first_q;
		ptr_d = ptr_q;
		drive_d = drive_q;
		wr_en = 1'b0;
		wr_data = sh_q;
		if (stop_cond)
		begin
			st_d = ST_IDLE;
			drive_d = 1'b0;
		end
		else if (start_cond)
		begin
			st_d = ST_ADDR;
			bit_d = 4'h0;
			drive_d = 1'b0;
		end
		else
		begin
			unique case (st_q)
				ST_IDLE: ;
				ST_ADDR, ST_WR:
					if (scl_rise)
					begin
						sh_d = {sh_q[6:0], sda_s};
						bit_d = bit_q + 4'h1;
					end
					else if (scl_fall && bit_q == 4'h8)
					begin
						if (st_q == ST_ADDR)
						begin
							// foreign address: stay silent until next start
							if (sh_q[7:1] == crcs_pkg::SLAVE_ADDR)
							begin
								rw_d = sh_q[0];
								first_d = 1'b1;
								drive_d = 1'b1;
								st_d = ST_ADDR_ACK;
							end
							else
								st_d = ST_IDLE;
						end
						else
						begin
							if (first_q)
								ptr_d = sh_q;
							else
							begin
								wr_en = 1'b1;
								ptr_d = ptr_q + 8'h01;
							end
							first_d = 1'b0;
							drive_d = 1'b1;
							st_d = ST_WR_ACK;
						end
					end
				ST_ADDR_ACK, ST_WR_ACK:
					if (scl_fall)
					begin
						bit_d = 4'h0;
						if (st_q == ST_ADDR_ACK && rw_q)
						begin
							sh_d = reg_read(ptr_q);
							drive_d = ~sh_d[7];
							st_d = ST_RD;
						end
						else
						begin
							drive_d = 1'b0;
							st_d = ST_WR;
						end
					end
				ST_RD:
					if (scl_fall)
					begin
						if (bit_q == 4'h7)
						begin
							drive_d = 1'b0;
							ptr_d = ptr_q + 8'h01;
							st_d = ST_RD_ACK;
						end
						else
						begin
							sh_d = {sh_q[6:0], 1'b0};
							drive_d = ~sh_q[6];
							bit_d = bit_q + 4'h1;
						end
					end
				ST_RD_ACK:
					if (scl_rise)
						rw_d = ~sda_s;
					else if (scl_fall)
					begin
						bit_d = 4'h0;
						if (rw_q)
						begin
							sh_d = reg_read(ptr_q);
							drive_d = ~sh_d[7];
							st_d = ST_RD;
						end
						else
							st_d = ST_IDLE;
					end
			endcase
		end
	end
	always_ff @(posedge clock or negedge core_rstn)
	begin
		if (!core_rstn)
		begin
			st_q <= ST_IDLE;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			ptr_q <= 8'h00;
			drive_q <= 1'b0;
			sda_oe_n <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			rw_q <= rw_d;
			first_q <= first_d;
			ptr_q <= ptr_d;
			drive_q <= drive_d;
			// only SDA is ever pulled; there is no SCL output at all
			sda_oe_n <= ~drive_d;
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end
	// ----------------------------------------
	// register writes and power-stage trips
	// ----------------------------------------
	logic hp_clr;
	logic spk_clr;
	logic soft_rst_d;
	assign hp_clr = wr_en && page_q == 8'h01 && ptr_q == crcs_pkg::HP_DRV_REG
		&& wr_data[crcs_pkg::STAGE_RESET_BIT];
	assign spk_clr = wr_en && page_q == 8'h01 && ptr_q == crcs_pkg::SPK_DRV_REG
		&& wr_data[crcs_pkg::STAGE_RESET_BIT];
	assign soft_rst_d = wr_en && page_q == 8'h00 && ptr_q == crcs_pkg::SW_RESET_REG
		&& wr_data[crcs_pkg::SW_RESET_BIT];
	// trip set wins over a clear in the same cycle
	assign hp_trip_d = ~hp_oc_s | (hp_trip_q & ~hp_clr);
	assign spk_trip_d = ~spk_oc_s | (spk_trip_q & ~spk_clr);
	always_ff @(posedge clock or negedge core_rstn)
	begin
		if (!core_rstn)
		begin
			for (int i = 0; i < crcs_pkg::REG_DEPTH; i++)
			begin
				regs_q[i] <= crcs_pkg::REG_RESET;
				regs1_q[i] <= crcs_pkg::REG_RESET;
			end
			page_q <= 8'h00;
			hp_trip_q <= 1'b0;
			spk_trip_q <= 1'b0;
		end
		else
		begin
			hp_trip_q <= hp_trip_d;
			spk_trip_q <= spk_trip_d;
			if (wr_en)
			begin
				// reset bits are never stored, so they read back zero
				if (ptr_q == crcs_pkg::PAGE_SEL_REG)
					page_q <= wr_data;
				else if (ptr_q < 8'(crcs_pkg::REG_DEPTH))
				begin
					if (page_q == 8'h00 && ptr_q == crcs_pkg::SW_RESET_REG)
						regs_q[ptr_q[5:0]] <= 8'h00;
					else if (page_q == 8'h00)
						regs_q[ptr_q[5:0]] <= wr_data;
					else if (hp_clr || spk_clr)
						regs1_q[ptr_q[5:0]] <= {1'b0, wr_data[6:0]};
					else
						regs1_q[ptr_q[5:0]] <= wr_data;
				end
			end
		end
	end
	// soft reset pulse lives on the pin reset only, so it ends itself
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			soft_rst_q <= 1'b0;
		else
			soft_rst_q <= soft_rst_d & ~soft_rst_q;
	end
	// ----------------------------------------
	// init busy timer, pll delay and power outputs
	// ----------------------------------------
	logic init_started_q;
	logic init_done;
	logic pll_req;
	logic pll_req_q;
	logic [7:0] pwr;
	assign pwr = regs_q[crcs_pkg::PWR_CTRL_REG[5:0]];
	assign pll_req = pwr[crcs_pkg::PWR_PLL_BIT];
	// done and busy flops add two edges; take them off so busy ends inside the bound
	crcs_timer #(.CYCLES(crcs_pkg::INIT_CYCLES - crcs_pkg::INIT_LAG_CYCLES)) u_init (
		.clock(clock), .rstn(core_rstn), .start(~init_started_q), .stop(1'b0),
		.done(init_done));
	crcs_timer #(.CYCLES(crcs_pkg::PLL_CYCLES)) u_pll (
		.clock(clock), .rstn(core_rstn), .start(pll_req & ~pll_req_q), .stop(~pll_req),
		.done(pll_done));
	always_ff @(posedge clock or negedge core_rstn)
	begin
		if (!core_rstn)
		begin
			init_started_q <= 1'b0;
			pll_req_q <= 1'b0;
			init_busy <= 1'b1;
			pll_clk_enable <= 1'b0;
			adc_power_up <= 1'b0;
			dac_power_up <= 1'b0;
			headphone_output_enable <= 1'b0;
			speaker_out_enable <= 1'b0;
		end
		else
		begin
			init_started_q <= 1'b1;
			pll_req_q <= pll_req;
			init_busy <= ~init_done;
			// power bits only gate outputs; settings stay intact
			pll_clk_enable <= pll_done;
			adc_power_up <= pwr[crcs_pkg::PWR_ADC_BIT];
			dac_power_up <= pwr[crcs_pkg::PWR_DAC_BIT];
			headphone_output_enable <= pwr[crcs_pkg::PWR_HP_BIT] & ~hp_trip_d;
			speaker_out_enable <= pwr[crcs_pkg::PWR_SPK_BIT] & ~spk_trip_d;
		end
	end
endmodule

//--- rtl/crcs_pkg.sv
package crcs_pkg;
	// ----------------------------------------
	// bus identity and timing
	// ----------------------------------------
	localparam logic [6:0] SLAVE_ADDR = 7'h18;
	localparam int CLK_HZ = 10000000;
	localparam int INIT_TIME_US = 1000;
	localparam int INIT_CYCLES = (INIT_TIME_US * (CLK_HZ / 1000)) / 1000;
	localparam int INIT_LAG_CYCLES = 2;
	localparam int PLL_TIME_MS = 10;
	localparam int PLL_CYCLES = PLL_TIME_MS * (CLK_HZ / 1000);
	localparam int RST_HOLD_NS = 10;
	// ----------------------------------------
	// register map: page select at 0, pages 0 and 1
	// ----------------------------------------
	localparam logic [7:0] PAGE_SEL_REG = 8'h00;
	localparam logic [7:0] SW_RESET_REG = 8'h01;
	localparam int SW_RESET_BIT = 0;
	localparam logic [7:0] PWR_CTRL_REG = 8'h02;
	localparam logic [7:0] STATUS_REG = 8'h03;
	localparam logic [7:0] HP_DRV_REG = 8'h1F;
	localparam logic [7:0] SPK_DRV_REG = 8'h20;
	localparam int STAGE_RESET_BIT = 7;
	localparam int PWR_PLL_BIT = 0;
	localparam int PWR_ADC_BIT = 1;
	localparam int PWR_DAC_BIT = 2;
	localparam int PWR_HP_BIT = 3;
	localparam int PWR_SPK_BIT = 4;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int REG_DEPTH = 64;
endpackage

//--- rtl/crcs_sync.sv
`timescale 1ns/1ps
module crcs_sync
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic din,
	output logic dout
);
	logic meta_q;
	logic sync_q;
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end
		else
		begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end
	assign dout = sync_q;
endmodule

//--- rtl/crcs_timer.sv
`timescale 1ns/1ps
// one-shot countdown; done is high once the count has elapsed since start
module crcs_timer
#(
	parameter int CYCLES = 16
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic start,
	input wire logic stop,
	output logic done
);
	logic [23:0] cnt_q;
	logic [23:0] cnt_d;
	logic run_q;
	logic run_d;
	logic done_q;
	logic done_d;
	always_comb
	begin
		cnt_d = cnt_q;
		run_d = run_q;
		done_d = done_q;
		if (stop)
		begin
			run_d = 1'b0;
			done_d = 1'b0;
		end
		else if (start)
		begin
			run_d = 1'b1;
			done_d = 1'b0;
			cnt_d = 24'(CYCLES - 1);
		end
		else if (run_q)
		begin
			if (cnt_q == 24'h000000)
			begin
				run_d = 1'b0;
				done_d = 1'b1;
			end
			else
				cnt_d = cnt_q - 24'h000001;
		end
	end
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q <= 24'h000000;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end
	assign done = done_q;
endmodule

//--- tb/crcs_top_sva.sv
`timescale 1ns/1ps
module crcs_top_sva
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe_n,
	input wire logic hp_overcurrent,
	input wire logic spk_overcurrent,
	input wire logic init_busy,
	input wire logic pll_clk_enable,
	input wire logic adc_power_up,
	input wire logic dac_power_up,
	input wire logic headphone_output_enable,
	input wire logic speaker_out_enable
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	logic [13:0] busy_q;
	logic [13:0] busy_d;
	logic [16:0] idle_q;
	logic [16:0] idle_d;
	logic any_on;
	// --------
	// cycle counts of init and of time since init ended
	// --------
	always_comb
	begin
		busy_d = init_busy ? busy_q + 14'h1 : 14'h0;
		idle_d = init_busy ? 17'h0 : idle_q + 17'(idle_q != 17'h1FFFF);
		any_on = adc_power_up | dac_power_up | headphone_output_enable | speaker_out_enable;
	end
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_q <= 14'h0;
			idle_q <= 17'h0;
		end
		else
		begin
			busy_q <= busy_d;
			idle_q <= idle_d;
		end
	end
	sequence hp_trip;
		$rose(hp_overcurrent);
	endsequence
	sequence spk_trip;
		$rose(spk_overcurrent);
	endsequence
	chk_reset_state: assert property ($rose(rstn) |-> init_busy && sda_oe_n && !any_on)
		else $error("outputs not at reset state");
	chk_busy_quiet: assert property (init_busy |-> !any_on && !pll_clk_enable)
		else $error("block powered during init");
	chk_init_bound: assert property (busy_q <= 14'h2711)
		else $error("init too long");
	chk_init_short: assert property ($fell(init_busy) |-> busy_q >= 14'h2706)
		else $error("init ended early");
	chk_pll_delay: assert property ($rose(pll_clk_enable) |-> idle_q >= 17'h186A0)
		else $error("pll clock given early");
	chk_no_start: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("sda pulled while scl high");
	chk_no_stop: assert property ($rose(sda_oe_n) |-> !scl_in)
		else $error("sda freed while scl high");
	chk_hp_trip: assert property (hp_trip |-> ##[1:5] !headphone_output_enable)
		else $error("headphone trip missed");
	chk_spk_trip: assert property (spk_trip |-> ##[1:5] !speaker_out_enable)
		else $error("speaker trip missed");
	chk_trip_apart: assert property ($rose(hp_overcurrent) && !spk_overcurrent
		|-> $stable(speaker_out_enable)[*6])
		else $error("speaker hit by hp trip");
endmodule
bind crcs_top crcs_top_sva chk
(
	.clock(clock),
	.rstn(rstn),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_oe_n(sda_oe_n),
	.hp_overcurrent(hp_overcurrent),
	.spk_overcurrent(spk_overcurrent),
	.init_busy(init_busy),
	.pll_clk_enable(pll_clk_enable),
	.adc_power_up(adc_power_up),
	.dac_power_up(dac_power_up),
	.headphone_output_enable(headphone_output_enable),
	.speaker_out_enable(speaker_out_enable)
);

//--- tb/crcs_host.sv
`timescale 1ns/1ps
module crcs_host
(
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	// quarter bit of 7 cycles: 357 kHz, under the fast rate
	task automatic tq(input int n);
		repeat (n * 7) @(negedge clock);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		tq(1);
		scl = 1'b1;
		tq(1);
		r = sda;
		tq(1);
		scl = 1'b0;
		tq(1);
	endtask
	task automatic start();
		sda_pull = 1'b0;
		scl = 1'b1;
		tq(1);
		sda_pull = 1'b1;
		tq(1);
		scl = 1'b0;
		tq(1);
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		tq(1);
		scl = 1'b1;
		tq(1);
		sda_pull = 1'b0;
		tq(2);
	endtask
	// 8 bits msb first, then the ninth bit; ack is the device pulling low
	task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(nack, ack);
		ack = !ack;
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d[$],
		output logic ok);
		logic [7:0] q;
		logic a;
		start();
		xfer({dev, 1'b0}, 1'b1, q, ok);
		xfer(ptr, 1'b1, q, a);
		foreach (d[i])
		begin
			xfer(d[i], 1'b1, q, a);
			ok &= a;
		end
		stop();
	endtask
	task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] d[$]);
		logic [7:0] q;
		logic a;
		d = {};
		start();
		xfer({crcs_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, a);
		xfer(ptr, 1'b1, q, a);
		start();
		xfer({crcs_pkg::SLAVE_ADDR, 1'b1}, 1'b1, q, a);
		for (int i = 0; i < n; i++)
		begin
			xfer(8'hFF, 1'(i == n - 1), q, a);
			d.push_back(q);
		end
		stop();
	endtask
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
endmodule

//--- tb/test_crcs_top.sv
`timescale 1ns/1ps
module test_crcs_top;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic hp_oc = 1'b0;
	logic spk_oc = 1'b0;
	logic scl, sda_pull, sda, sda_oe_n, init_busy, pll_en, adc, dac, hp, spk, ok;
	logic [7:0] rb[$];
	logic [7:0] pat[4] = '{8'h5A, 8'hC3, 8'h01, 8'hFF};
	int fails = 0;
	int checks = 0;
	always #50 clock = ~clock;
	// open-drain line with pull-up
	assign sda = !(sda_pull || !sda_oe_n);
	crcs_top dut (.clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_oe_n(sda_oe_n),
		.hp_overcurrent(hp_oc), .spk_overcurrent(spk_oc), .init_busy(init_busy),
		.pll_clk_enable(pll_en), .adc_power_up(adc), .dac_power_up(dac),
		.headphone_output_enable(hp), .speaker_out_enable(spk));
	crcs_host host (.clock(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] outs();
		return {2'h0, init_busy, pll_en, adc, dac, hp, spk};
	endfunction
	task automatic wr1(input logic [7:0] a, input logic [7:0] d);
		host.wr(crcs_pkg::SLAVE_ADDR, a, {d}, ok);
		cmp(8'(ok), 8'h01);
	endtask
	task automatic rd1(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, 1, rb);
		cmp(rb[0], exp);
	endtask
	task automatic cmp_pat();
		host.rd(8'h04, 4, rb);
		foreach (rb[i])
			cmp(rb[i], pat[i]);
	endtask
	// writes are not held off during init, so the host waits it out before powering anything
	task automatic wait_init();
		int n;
		n = 0;
		while (init_busy === 1'b1 && n < 10100)
		begin
			@(negedge clock);
			n++;
		end
		cmp(8'(n > 9900 && n < 10100), 8'h01);
		cmp(outs(), 8'h00);
	endtask
	task automatic end_of_test();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge clock);
		cmp(outs(), 8'h20);
		rstn = 1'b1;
		wait_init();
		host.wr(7'h19, 8'h05, {8'hA5}, ok);
		cmp(8'(ok), 8'h00);
		rd1(8'h05, 8'h00);
		host.wr(crcs_pkg::SLAVE_ADDR, 8'h04, {8'h5A, 8'hC3, 8'h01, 8'hFF}, ok);
		cmp(8'(ok), 8'h01);
		cmp_pat();
		$display("test bus done");
		for (int b = 1; b < 5; b++)
		begin
			wr1(crcs_pkg::PWR_CTRL_REG, 8'(1 << b));
			cmp(outs(), 8'(1 << (4 - b)));
		end
		wr1(crcs_pkg::PWR_CTRL_REG, 8'h01);
		repeat (1000) @(negedge clock);
		cmp(outs(), 8'h00);
		cmp_pat();
		$display("test power done");
		wr1(crcs_pkg::PWR_CTRL_REG, 8'h18);
		for (int s = 0; s < 2; s++)
		begin
			{hp_oc, spk_oc} = 2'(2 >> s);
			repeat (10) @(negedge clock);
			{hp_oc, spk_oc} = 2'h0;
			repeat (10) @(negedge clock);
			cmp(outs(), 8'(1 << s));
			wr1(crcs_pkg::PAGE_SEL_REG, 8'h01);
			wr1(8'(crcs_pkg::HP_DRV_REG + 8'(s)), 8'h80);
			cmp(outs(), 8'h03);
			rd1(8'(crcs_pkg::HP_DRV_REG + 8'(s)), 8'h00);
			wr1(crcs_pkg::PAGE_SEL_REG, 8'h00);
		end
		cmp_pat();
		$display("test trip done");
		// the ack of a reset write may be cut short, so it is not judged
		host.wr(crcs_pkg::SLAVE_ADDR, crcs_pkg::SW_RESET_REG, {8'h01}, ok);
		cmp(outs(), 8'h20);
		wait_init();
		rd1(8'h04, 8'h00);
		rd1(crcs_pkg::SW_RESET_REG, 8'h00);
		wr1(crcs_pkg::PWR_CTRL_REG, 8'h06);
		rstn = 1'b0;
		@(negedge clock);
		cmp(outs(), 8'h20);
		rstn = 1'b1;
		wait_init();
		rd1(crcs_pkg::PWR_CTRL_REG, 8'h00);
		$display("test reset done");
		end_of_test();
	end
	initial
	begin
		// tests need about 60000 cycles
		repeat (90000) @(posedge clock);
		fails++;
		end_of_test();
	end
endmodule
